// File: spm_pkg.sv
// Constants and types shared by the serial port master/slave block.
`default_nettype none
package spm_pkg;

    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam logic [1:0] SPM_CTRL_OFS = 2'h0;
    localparam logic [1:0] SPM_STAT_OFS = 2'h1;
    localparam logic [1:0] SPM_DATA_OFS = 2'h2;

    // ------------------------------------------------------------------
    // Control register fields.
    // ------------------------------------------------------------------
    localparam int SPM_IRQ_EN_BIT = 7;
    localparam int SPM_PORT_EN_BIT = 6;
    localparam int SPM_LSB_FIRST_BIT = 5;
    localparam int SPM_MASTER_BIT = 4;
    localparam int SPM_IDLE_LVL_BIT = 3;
    localparam int SPM_PHASE_BIT = 2;
    localparam int SPM_RATE_HI_BIT = 1;
    localparam int SPM_RATE_LO_BIT = 0;

    // ------------------------------------------------------------------
    // Status register fields.
    // ------------------------------------------------------------------
    localparam int SPM_XFER_FLAG_BIT = 7;
    localparam int SPM_WRITE_COLLISION_FLAG_BIT = 6;
    localparam int SPM_DBL_BIT = 0;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0] SPM_CTRL_RST = 8'h00;
    localparam logic [7:0] SPM_DATA_RST = 8'h00;
    localparam logic [3:0] SPM_SYNC_RST = 4'h8;

    // ------------------------------------------------------------------
    // Pin indices of the synchronised inputs.
    // ------------------------------------------------------------------
    localparam int SPM_PIN_MOSI = 0;
    localparam int SPM_PIN_MISO = 1;
    localparam int SPM_PIN_SCK = 2;
    localparam int SPM_PIN_SS = 3;

    // ------------------------------------------------------------------
    // Timing: half SCK period in core clocks, indexed {double, rate[1:0]}.
    // ------------------------------------------------------------------
    localparam logic [7:0][6:0] SPM_HALF_TBL = {7'h20, 7'h10, 7'h04, 7'h01,
                                                 7'h40, 7'h20, 7'h08, 7'h02};
    localparam logic [3:0] SPM_LAST_EDGE = 4'hF;
    localparam logic [2:0] SPM_LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        SPM_IDLE = 2'b00,
        SPM_SHIFT = 2'b01
    } spm_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic dbl;
        logic xfer_flag;
        logic write_collision_flag;
        logic arm_flag;
        logic arm_write_collision_flag;
        logic [7:0] rxbuf;
        logic [7:0] sh;
        logic out_bit;
        logic sck;
        spm_state_t state;
        logic [3:0] edge_cnt;
        logic [6:0] div;
        logic [2:0] bits;
        logic [7:0] rdata;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] flt;
        logic sck_prev;
        logic [4:0] tog;
    } spm_regs_t;

endpackage
`default_nettype wire

// File: spm_top.sv
// Byte-wide serial peripheral port, master or slave, with its register file.
//
// Summary of operation
// R01 - Slave: select input, MISO drives when enabled
// R02 - Select high resets slave logic, drops byte
// R03 - Master select output pin is ignored
// R04 - Master select low forces slave, sets flag
// R05 - Outside keeps select-input high for master
// R06 - Software re-arms master after fall-back
// R07 - Interrupt from enable, flag, global enable
// R08 - Nothing operates unless port enabled
// R09 - Bit order: one means LSB first
// R10 - Role bit: one master, zero slave
// R11 - Idle level selects SCK idle polarity
// R12 - Phase selects sample leading or trailing
// R13 - Rate bits and double select divider
// R14 - Flag sets on byte done, fault
// R15 - Flag clears by vector or read-then-access
// R16 - Collision flag on busy data write
// R17 - Status reserved bits read zero
// R18 - Double speed halves master SCK period
// R19 - External SCK at most quarter core clock
// R20 - Data write starts, read gives buffer
// R21 - Output and capture on opposite edges
// R22 - Master issues exactly eight clocks, stops
// R23 - Receive buffer overwritten by next byte
// R24 - Deselected slave keeps MISO off, ignores SCK
// R25 - Slave SCK synchronised and edge detected
// R26 - Three-bit counter clears per byte, deselect
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module spm_top (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic GLOBAL_IRQ_EN,
    input wire logic IRQ_ACK,
    output logic IRQ,
    input wire logic MOSI_DIR,
    input wire logic MISO_DIR,
    input wire logic SCK_DIR,
    input wire logic SS_DIR,
    input wire logic MOSI_I,
    output logic MOSI_O,
    output logic MOSI_OE,
    input wire logic MISO_I,
    output logic MISO_O,
    output logic MISO_OE,
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE,
    input wire logic SS_I
);
    import spm_pkg::*;

    // ------------------------------------------------------------------
    // State and decoded control.
    // ------------------------------------------------------------------
    localparam spm_regs_t SPM_REGS_RST = '{
        ctrl: SPM_CTRL_RST, dbl: 1'b0, xfer_flag: 1'b0, write_collision_flag: 1'b0,
        arm_flag: 1'b0, arm_write_collision_flag: 1'b0, rxbuf: SPM_DATA_RST,
        sh: SPM_DATA_RST, out_bit: 1'b0, sck: 1'b0, state: SPM_IDLE,
        edge_cnt: 4'h0, div: 7'h00, bits: 3'h0, rdata: 8'h00,
        s1: SPM_SYNC_RST, s2: SPM_SYNC_RST, s3: SPM_SYNC_RST,
        flt: SPM_SYNC_RST, sck_prev: 1'b0, tog: 5'h00};

    spm_regs_t s_q;
    spm_regs_t s_d;
    logic en;
    logic master;
    logic lsb_first;
    logic idle_lvl;
    logic phase;
    logic [6:0] half;
    logic ss_f;
    logic sck_f;
    logic din;
    logic busy_any;
    logic dat_acc;
    logic xfer_done;
    logic mode_fault;
    logic lead_ev;
    logic trail_ev;
    logic sample_ev;
    logic setup_ev;
    logic [7:0] sh_next;

    assign en = s_q.ctrl[SPM_PORT_EN_BIT];
    assign master = s_q.ctrl[SPM_MASTER_BIT];
    assign lsb_first = s_q.ctrl[SPM_LSB_FIRST_BIT];
    assign idle_lvl = s_q.ctrl[SPM_IDLE_LVL_BIT];
    assign phase = s_q.ctrl[SPM_PHASE_BIT];
    // R13 rate select
    // R18 double speed
    assign half = SPM_HALF_TBL[{s_q.dbl, s_q.ctrl[SPM_RATE_HI_BIT], s_q.ctrl[SPM_RATE_LO_BIT]}];
    assign ss_f = s_q.flt[SPM_PIN_SS];
    assign sck_f = s_q.flt[SPM_PIN_SCK];
    assign din = master ? s_q.flt[SPM_PIN_MISO] : s_q.flt[SPM_PIN_MOSI];
    // R09 bit order
    assign sh_next = lsb_first ? {din, s_q.sh[7:1]} : {s_q.sh[6:0], din};
    assign busy_any = (s_q.state == SPM_SHIFT) || (!master && s_q.bits != 3'h0);
    assign dat_acc = (WR || RD) && ADDR == SPM_DATA_OFS;

    // ------------------------------------------------------------------
    // Pin drivers.
    // ------------------------------------------------------------------
    // R08 quiet when disabled
    // R10 role picks pin directions
    assign MOSI_O = s_q.out_bit;
    assign MOSI_OE = en && master && MOSI_DIR;
    assign SCK_O = s_q.sck;
    assign SCK_OE = en && master && SCK_DIR;
    // R01 slave MISO drive
    // R24 deselected slave tri-state
    assign MISO_O = s_q.out_bit;
    assign MISO_OE = en && !master && !ss_f && MISO_DIR;
    // R07 interrupt request
    assign IRQ = s_q.xfer_flag && s_q.ctrl[SPM_IRQ_EN_BIT] && GLOBAL_IRQ_EN;
    assign RDATA = s_q.rdata;

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        xfer_done = 1'b0;
        mode_fault = 1'b0;
        lead_ev = 1'b0;
        trail_ev = 1'b0;

        // R25 synchronise pins
        // A level counts only once the second and third stages agree, so a
        // glitch shorter than a core period never reaches the shifter.
        s_d.s1 = {SS_I, SCK_I, MISO_I, MOSI_I};
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        for (int i = 0; i < 4; i++) begin
            if (s_q.s2[i] == s_q.s3[i]) begin
                s_d.flt[i] = s_q.s3[i];
            end
        end
        s_d.sck_prev = sck_f;

        // Register writes.
        if (WR && ADDR == SPM_CTRL_OFS) begin
            s_d.ctrl = WDATA;
        end
        if (WR && ADDR == SPM_STAT_OFS) begin
            s_d.dbl = WDATA[SPM_DBL_BIT];
        end

        // R15 read-then-access clear
        if (dat_acc) begin
            if (s_q.arm_flag || s_q.arm_write_collision_flag) begin
                s_d.xfer_flag = 1'b0;
            end
            if (s_q.arm_write_collision_flag) begin
                s_d.write_collision_flag = 1'b0;
            end
            s_d.arm_flag = 1'b0;
            s_d.arm_write_collision_flag = 1'b0;
        end
        if (IRQ_ACK) begin
            s_d.xfer_flag = 1'b0;
        end

        // R20 data write starts
        if (WR && ADDR == SPM_DATA_OFS && en) begin
            if (!busy_any) begin
                s_d.sh = WDATA;
                s_d.out_bit = lsb_first ? WDATA[0] : WDATA[7];
                if (master) begin
                    s_d.state = SPM_SHIFT;
                    s_d.edge_cnt = 4'h0;
                    s_d.div = half - 7'h01;
                    s_d.tog = 5'h00;
                end
            end
        end

        // R04 master fall-back
        // R03 select output ignored
        mode_fault = en && master && !SS_DIR && !ss_f;

        if (!en) begin
            s_d.state = SPM_IDLE;
            s_d.bits = 3'h0;
            s_d.edge_cnt = 4'h0;
            s_d.sck = idle_lvl;
        end else if (mode_fault) begin
            s_d.ctrl[SPM_MASTER_BIT] = 1'b0;
            s_d.state = SPM_IDLE;
            s_d.bits = 3'h0;
            s_d.edge_cnt = 4'h0;
            s_d.sck = idle_lvl;
        end else if (master) begin
            if (s_q.state == SPM_SHIFT) begin
                if (s_q.div == 7'h00) begin
                    s_d.div = half - 7'h01;
                    s_d.sck = ~s_q.sck;
                    s_d.tog = s_q.tog + 5'h01;
                    s_d.edge_cnt = s_q.edge_cnt + 4'h1;
                    lead_ev = !s_q.edge_cnt[0];
                    trail_ev = s_q.edge_cnt[0];
                    // R22 eight clocks then stop
                    if (s_q.edge_cnt == SPM_LAST_EDGE) begin
                        s_d.state = SPM_IDLE;
                        xfer_done = 1'b1;
                    end
                end else begin
                    s_d.div = s_q.div - 7'h01;
                end
            end else begin
                // R11 idle level
                s_d.sck = idle_lvl;
            end
        end else begin
            s_d.state = SPM_IDLE;
            s_d.sck = idle_lvl;
            if (ss_f) begin
                // R02 deselect resets
                // R26 counter clears on deselect
                s_d.bits = 3'h0;
            end else if (sck_f != s_q.sck_prev) begin
                // R11 leading edge leaves idle level
                lead_ev = (sck_f != idle_lvl);
                trail_ev = (sck_f == idle_lvl);
            end
        end

        // R12 phase picks sample edge
        // R21 opposite edges
        sample_ev = phase ? trail_ev : lead_ev;
        setup_ev = phase ? lead_ev : trail_ev;
        if (sample_ev) begin
            s_d.sh = sh_next;
            // R26 wraps at byte boundary
            s_d.bits = s_q.bits + 3'h1;
            if (!master && s_q.bits == SPM_LAST_BIT) begin
                xfer_done = 1'b1;
            end
        end
        if (setup_ev) begin
            s_d.out_bit = lsb_first ? s_q.sh[0] : s_q.sh[7];
        end

        // R23 receive buffer overwrite
        if (xfer_done) begin
            s_d.rxbuf = s_d.sh;
        end

        // Status read arms the clear; sets below win over any clear.
        if (RD && ADDR == SPM_STAT_OFS) begin
            s_d.arm_flag = s_q.xfer_flag;
            s_d.arm_write_collision_flag = s_q.write_collision_flag;
        end
        // R14 flag set
        if (xfer_done || mode_fault) begin
            s_d.xfer_flag = 1'b1;
        end
        // R16 collision set
        if (WR && ADDR == SPM_DATA_OFS && en && busy_any) begin
            s_d.write_collision_flag = 1'b1;
        end

        // Register reads, answered in the following cycle.
        if (RD) begin
            case (ADDR)
                SPM_CTRL_OFS: s_d.rdata = s_q.ctrl;
                // R17 reserved zero
                SPM_STAT_OFS: s_d.rdata = {s_q.xfer_flag, s_q.write_collision_flag, 5'h00, s_q.dbl};
                SPM_DATA_OFS: s_d.rdata = s_q.rxbuf;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= SPM_REGS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_flag_armed;
        RD && ADDR == SPM_STAT_OFS && s_q.xfer_flag;
    endsequence

    sequence s_data_access_clean;
        RD && ADDR == SPM_DATA_OFS && !xfer_done && !mode_fault;
    endsequence

    sequence s_master_start;
        WR && ADDR == SPM_DATA_OFS && en && master && !busy_any && !mode_fault;
    endsequence

    sequence s_bus_quiet;
        !RD && !WR;
    endsequence

    property p_deselect_reset;
        en && !master && !ss_f ##1 ss_f && en && !master |=> s_q.bits == 3'h0;
    endproperty
    a_deselect_reset: assert property (p_deselect_reset) else $error("slave counter not reset"); // R02

    property p_fallback;
        en && master && !SS_DIR && !ss_f |=> !s_q.ctrl[SPM_MASTER_BIT] && s_q.xfer_flag && !SCK_OE;
    endproperty
    a_fallback: assert property (p_fallback) else $error("no fall-back to slave"); // R04

    property p_irq;
        $rose(s_q.xfer_flag) && s_q.ctrl[SPM_IRQ_EN_BIT] && GLOBAL_IRQ_EN |-> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised"); // R07

    property p_disabled;
        !en |-> !SCK_OE && !MOSI_OE && !MISO_OE;
    endproperty
    a_disabled: assert property (p_disabled) else $error("pin driven while disabled"); // R08

    property p_reserved;
        RD && ADDR == SPM_STAT_OFS |=> RDATA[5:1] == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // R17

    property p_eight_clocks;
        $fell(s_q.state == SPM_SHIFT) && $past(!mode_fault && en) |-> s_q.tog == 5'h10;
    endproperty
    a_eight_clocks: assert property (p_eight_clocks) else $error("not eight clocks"); // R22

    // R22 shift cycle count
    // A slow transfer outlasts any delay range worth unrolling, so its
    // length is kept in a small counter and the bound is checked on that.
    logic [10:0] shift_cyc_q;
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            shift_cyc_q <= 11'h000;
        end else if (s_q.state == SPM_SHIFT) begin
            shift_cyc_q <= shift_cyc_q + 11'h001;
        end else begin
            shift_cyc_q <= 11'h000;
        end
    end

    property p_start;
        s_master_start |=> s_q.state == SPM_SHIFT && shift_cyc_q == 11'h000;
    endproperty
    a_start: assert property (p_start) else $error("transfer did not start"); // R20

    property p_shift_bound;
        s_q.state == SPM_SHIFT |-> shift_cyc_q < {half, 4'h0};
    endproperty
    a_shift_bound: assert property (p_shift_bound) else $error("transfer did not end in time"); // R22

    property p_collision;
        WR && ADDR == SPM_DATA_OFS && en && busy_any |=> s_q.write_collision_flag;
    endproperty
    a_collision: assert property (p_collision) else $error("collision not flagged"); // R16

    property p_flag_clear;
        s_flag_armed ##1 s_bus_quiet ##1 s_data_access_clean |=> !s_q.xfer_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // R15

    property p_idle_level;
        en && master && s_q.state == SPM_IDLE && $past(s_q.state == SPM_IDLE) && $stable(idle_lvl)
            |-> s_q.sck == idle_lvl;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("SCK not at idle level"); // R11

endmodule // spm_top
`default_nettype wire

// File: spm_partner.sv
// Far-side model: a slave answering a master port, or a master driving a slave port.
`timescale 1ns/100ps
`default_nettype none
module spm_partner #(
    parameter int HALF = 8
) (
    input wire logic clk,
    input wire logic clock_idle_level,
    input wire logic clock_phase,
    input wire logic lsb,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    output var logic miso_o,
    output var logic sck_o,
    output var logic mosi_o,
    output var logic ss_n_o
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    logic act = 1'b0;
    logic pat = 1'b0;
    logic sck_q = 1'b0;
    int edges = 0;
    int k;
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        ss_n_o = 1'b1;
    end
    always @(posedge clk) begin
        sck_q <= sck;
        pat <= ~pat;
        if (sck !== sck_q) begin
            edges <= edges + 1;
            if (edges[0] == clock_phase) begin
                rx <= lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
            end
        end
    end
    // setup after sample
    // The line toggles every cycle while not armed so a stale bit is never mistaken for data.
    always_comb begin
        k = (edges - int'(clock_phase)) / 2;
        if (k > 7) begin
            k = 7;
        end
        miso_o = act ? (lsb ? tx[k] : tx[7 - k]) : pat;
    end
    task automatic arm(input logic [7:0] d);
        tx = d;
        edges = 0;
        act = 1'b1;
    endtask
    task automatic send(input logic [7:0] d, input int nb, output logic [7:0] got);
        int i;
        got = 8'h00;
        act = 1'b0;
        sck_o <= clock_idle_level;
        repeat (HALF) @(posedge clk);
        ss_n_o <= 1'b0;
        repeat (HALF) @(posedge clk);
        for (i = 0; i < nb; i++) begin
            if (clock_phase) begin
                sck_o <= ~sck_o;
            end
            mosi_o <= lsb ? d[i] : d[7 - i];
            repeat (HALF) @(posedge clk);
            sck_o <= ~sck_o;
            got = lsb ? {miso, got[7:1]} : {got[6:0], miso};
            repeat (HALF) @(posedge clk);
            if (!clock_phase) begin
                sck_o <= ~sck_o;
            end
        end
        repeat (HALF) @(posedge clk);
        ss_n_o <= 1'b1;
        mosi_o <= ~mosi_o;
    endtask
endmodule // spm_partner
`default_nettype wire

// File: spm_top_tb.sv
// Self-checking bench for the serial port block against its far-side model.
`timescale 1ns/100ps
`default_nettype none
module spm_top_tb;
    import spm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic gie = 1'b0;
    logic ack = 1'b0;
    logic ss_dir = 1'b1;
    logic miso_dir = 1'b1;
    logic ss_tb = 1'b1;
    logic [7:0] ctl = 8'h00;
    logic [7:0] rdata;
    logic irq, mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe;
    logic p_miso, p_sck, p_mosi, p_ss_n;
    logic sck_d = 1'b0;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_edge = 0;
    int first_e = 0;
    int last_e = 0;
    wire sck_w = sck_oe ? sck_o : p_sck;
    wire mosi_w = mosi_oe ? mosi_o : p_mosi;
    wire miso_w = miso_oe ? miso_o : p_miso;
    wire ss_w = p_ss_n & ss_tb;

    spm_top i_dut (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .GLOBAL_IRQ_EN(gie), .IRQ_ACK(ack), .IRQ(irq), .MOSI_DIR(1'b1),
        .MISO_DIR(miso_dir), .SCK_DIR(1'b1), .SS_DIR(ss_dir), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
        .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe), .SCK_I(sck_w),
        .SCK_O(sck_o), .SCK_OE(sck_oe), .SS_I(ss_w));
    spm_partner #(.HALF(8)) i_partner (.clk(clk), .clock_idle_level(ctl[SPM_IDLE_LVL_BIT]),
        .clock_phase(ctl[SPM_PHASE_BIT]), .lsb(ctl[SPM_LSB_FIRST_BIT]), .sck(sck_w), .mosi(mosi_w),
        .miso(miso_w), .miso_o(p_miso), .sck_o(p_sck), .mosi_o(p_mosi), .ss_n_o(p_ss_n));

    initial begin
        forever #25 clk = ~clk;
    end
    // Counts SCK edges and a generous cycle ceiling against hangs.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sck_d <= sck_w;
        if (sck_w !== sck_d) begin
            n_edge <= n_edge + 1;
            last_e <= cyc;
            if (n_edge == 0) begin
                first_e <= cyc;
            end
        end
        if (cyc == 60000) begin
            fail_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // Bus and check tasks.
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd_reg(a, v);
        chk(16'(v), 16'(e));
    endtask
    task automatic setc(input logic [7:0] c);
        ctl = c;
        wr_reg(SPM_CTRL_OFS, c);
        repeat (4) @(posedge clk);
    endtask
    task automatic wait_done(output logic [7:0] v);
        int n;
        v = 8'h00;
        for (n = 0; n < 1000 && v[7] !== 1'b1; n++) begin
            rd_reg(SPM_STAT_OFS, v);
        end
    endtask
    task automatic mxfer(input logic [7:0] db, input logic [7:0] pb, output logic [7:0] v);
        i_partner.arm(pb);
        n_edge = 0;
        wr_reg(SPM_DATA_OFS, db);
        wait_done(v);
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk(16'({sck_oe, mosi_oe, miso_oe}), 16'h0);
        rd_chk(SPM_CTRL_OFS, SPM_CTRL_RST);
        rd_chk(SPM_DATA_OFS, SPM_DATA_RST);
        rd_chk(2'h3, 8'h00);
        wr_reg(SPM_STAT_OFS, 8'hFF);
        rd_chk(SPM_STAT_OFS, 8'h01);
        wr_reg(2'h3, 8'hFF);
        rd_chk(SPM_CTRL_OFS, 8'h00);
        wr_reg(SPM_STAT_OFS, 8'h00);
    endtask
    task automatic t_irq();
        logic [7:0] v;
        setc(8'hD1);
        chk(16'({sck_oe, mosi_oe, miso_oe}), 16'h6);
        mxfer(8'h6B, 8'h94, v);
        chk(16'(irq), 16'h0);
        gie <= 1'b1;
        @(posedge clk);
        #1;
        chk(16'(irq), 16'h1);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        #1;
        chk(16'(irq), 16'h0);
        rd_chk(SPM_STAT_OFS, 8'h00);
        mxfer(8'h3C, 8'hC3, v);
        chk(16'(irq), 16'h1);
        rd_chk(SPM_DATA_OFS, 8'hC3);
        chk(16'(irq), 16'h0);
    endtask
    task automatic t_master();
        int m;
        logic [7:0] c, db, pb, v;
        for (m = 0; m < 8; m++) begin
            c = 8'h51;
            c[5] = m[2];
            c[3:2] = m[1:0];
            db = 8'h1D + 8'(m * 37);
            pb = 8'hC6 ^ 8'(m * 19);
            setc(c);
            mxfer(db, pb, v);
            chk(16'(v), 16'h0080);
            chk(16'(n_edge), 16'd16);
            chk(16'(sck_w), 16'(c[3]));
            chk(16'(irq), 16'h0);
            rd_chk(SPM_DATA_OFS, pb);
            chk(16'(i_partner.rx), 16'(db));
            rd_chk(SPM_STAT_OFS, 8'h00);
        end
    endtask
    task automatic t_rate();
        int div[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
        int r;
        logic [7:0] v;
        for (r = 0; r < 8; r++) begin
            setc(8'h50 | 8'(r & 3));
            wr_reg(SPM_STAT_OFS, 8'(r >> 2));
            mxfer(8'hA5, 8'h5A, v);
            chk(16'(last_e - first_e), 16'(15 * div[r] / 2));
            rd_reg(SPM_DATA_OFS, v);
        end
        wr_reg(SPM_STAT_OFS, 8'h00);
    endtask
    task automatic t_write_collision_flag();
        logic [7:0] v;
        setc(8'h51);
        i_partner.arm(8'h5A);
        wr_reg(SPM_DATA_OFS, 8'h96);
        wr_reg(SPM_DATA_OFS, 8'h11);
        rd_chk(SPM_STAT_OFS, 8'h40);
        wait_done(v);
        chk(16'(v), 16'h00C0);
        rd_chk(SPM_DATA_OFS, 8'h5A);
        rd_chk(SPM_STAT_OFS, 8'h00);
        chk(16'(i_partner.rx), 16'h0096);
    endtask
    task automatic t_disabled();
        setc(8'h10);
        n_edge = 0;
        wr_reg(SPM_DATA_OFS, 8'h3C);
        repeat (40) @(posedge clk);
        chk(16'(n_edge), 16'h0);
        chk(16'({sck_oe, mosi_oe}), 16'h0);
        rd_chk(SPM_STAT_OFS, 8'h00);
    endtask
    task automatic t_fault();
        logic [7:0] v;
        setc(8'h50);
        ss_tb <= 1'b0;
        repeat (10) @(posedge clk);
        rd_chk(SPM_CTRL_OFS, 8'h50);
        ss_tb <= 1'b1;
        repeat (10) @(posedge clk);
        ss_dir <= 1'b0;
        repeat (10) @(posedge clk);
        rd_chk(SPM_CTRL_OFS, 8'h50);
        ss_tb <= 1'b0;
        repeat (10) @(posedge clk);
        rd_chk(SPM_CTRL_OFS, 8'h40);
        chk(16'({sck_oe, mosi_oe}), 16'h0);
        chk(16'(miso_oe), 16'h1);
        miso_dir <= 1'b0;
        @(posedge clk);
        #1;
        chk(16'(miso_oe), 16'h0);
        miso_dir <= 1'b1;
        rd_chk(SPM_STAT_OFS, 8'h80);
        rd_reg(SPM_DATA_OFS, v);
        ss_tb <= 1'b1;
        ss_dir <= 1'b1;
        setc(8'h50);
        rd_chk(SPM_CTRL_OFS, 8'h50);
    endtask
    task automatic t_slave();
        int m;
        logic [7:0] c, db, pb, v;
        for (m = 0; m < 4; m++) begin
            c = 8'h40;
            c[3:2] = m[1:0];
            c[5] = m[0];
            db = 8'hB4 ^ 8'(m);
            pb = 8'h2E + 8'(m * 50);
            setc(c);
            wr_reg(SPM_DATA_OFS, db);
            chk(16'(miso_oe), 16'h0);
            i_partner.send(pb, 8, v);
            chk(16'(v), 16'(db));
            rd_chk(SPM_STAT_OFS, 8'h80);
            rd_chk(SPM_DATA_OFS, pb);
        end
        i_partner.send(8'hF0, 3, v);
        repeat (8) @(posedge clk);
        rd_chk(SPM_STAT_OFS, 8'h00);
        wr_reg(SPM_DATA_OFS, 8'h3C);
        i_partner.send(8'h81, 8, v);
        chk(16'(v), 16'h003C);
        i_partner.send(8'h55, 8, v);
        rd_chk(SPM_DATA_OFS, 8'h55);
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_irq();
        t_master();
        t_rate();
        t_write_collision_flag();
        t_disabled();
        t_fault();
        t_slave();
        finish_test();
    end
endmodule // spm_top_tb
`default_nettype wire
